// file: hw/fifo_dev.sv
// Behaviour
// - fall-through flag thresholds on count with output word
// - output ready low after first write; blocks reads
// - input ready high when full; blocks writes
// - default offsets 127 parallel, 1023 serial
// - master reset samples load select for method
// - method changes only at master reset, or at presetn, which loads parallel
// - parallel offset write steps byte pointer
// - parallel offset readback steps own byte pointer
// - serial shifts 32 bits, empty LSB first
// - no shift while serial enable high
// - writer always shifts complete offset set
// - partial flags invalid until two edges after
// - memory writes allowed around serial programming
// - serial shifting pauses and resumes in place
// - readback works under either method
// - same offset sequence in every timing mode
// - no serial readout of offsets
`timescale 1ns/100ps
`include "fifo_flag_cfg.svh"
module fifo_dev
   import fifo_flag_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   fifo_link_if.device link,
   output logic serial_method,
   output logic program_busy
);
   localparam dev_state_t DEV_RST = '{
      method_serial: 1'b0,
      out_valid: 1'b0,
      rdata: 9'h000,
      wr_idx: 16'h0000,
      rd_idx: 16'h0000,
      mem_cnt: 17'h00000,
      offs: {`OFF_DEF_PAR, `OFF_DEF_PAR},
      off_pipe: {`OFF_DEF_PAR, `OFF_DEF_PAR},
      wptr: 2'h0,
      rptr: 2'h0,
      spos: 5'h00,
      ser_busy: 1'b0
   };

   dev_state_t r;
   dev_state_t s;

   // storage kept out of the state struct: it is far too wide to copy each cycle
   logic [8:0] mem [0:65535];
   logic mem_we;
   logic [8:0] mem_q;
   logic [16:0] total;
   logic full;
   logic do_wr;
   logic do_rd;
   logic pop;
   logic ld;
   logic off_wr;
   logic off_rd;
   logic ser_shift;

   // one decode of the pin table shared by all offset paths; the pattern is
   // {load select, write enable, read enable, serial enable} as pin levels
   function automatic logic pins_match(
      input logic ld_i,
      input logic we_n,
      input logic re_n,
      input logic sen_n,
      input logic [3:0] want
   );
      return {ld_i, we_n, re_n, sen_n} == want;
   endfunction

   // byte lanes of the offset pair: lane 0 empty LSB up to lane 3 full MSB
   function automatic logic [7:0] off_byte(
      input logic [31:0] offs_i,
      input logic [1:0] ptr
   );
      return offs_i[{ptr, 3'b000} +: 8];
   endfunction

   function automatic logic [31:0] off_put(
      input logic [31:0] offs_i,
      input logic [1:0] ptr,
      input logic [7:0] b
   );
      logic [31:0] v;
      v = offs_i;
      v[{ptr, 3'b000} +: 8] = b;
      return v;
   endfunction

   // both offsets share one default; the method latched at master reset picks it
   function automatic logic [31:0] off_default(input logic serial);
      if (serial) begin
         return {`OFF_DEF_SER, `OFF_DEF_SER};
      end else begin
         return {`OFF_DEF_PAR, `OFF_DEF_PAR};
      end
   endfunction

   // a set counts as complete only once its last bit has landed
   function automatic logic set_complete(input logic [4:0] pos);
      return pos == `SER_LAST_BIT;
   endfunction

   assign mem_q = mem[r.rd_idx];
   assign total = r.mem_cnt + {16'h0000, r.out_valid};
   assign full = (total == `FIFO_CAP);

   always_comb begin
      s = r;
      mem_we = 1'b0;
      do_wr = 1'b0;
      do_rd = 1'b0;
      pop = 1'b0;
      off_wr = 1'b0;
      off_rd = 1'b0;
      ser_shift = 1'b0;
      ld = link.offset_load_select;
      if (!link.master_reset_n) begin
         s = DEV_RST;
         s.method_serial = ld;
         s.offs = off_default(ld);
         s.off_pipe = s.offs;
      end else begin
         // offset side; the same decode serves every timing mode
         off_wr = pins_match(ld, link.write_en_n, link.read_en_n, link.serial_enable_n,
            4'h3);
         off_rd = pins_match(ld, link.write_en_n, link.read_en_n, link.serial_enable_n,
            4'h5);
         ser_shift = pins_match(ld, link.write_en_n, link.read_en_n, link.serial_enable_n,
            4'h6);
         // memory side; write and read pins act independently
         do_wr = ld && !link.write_en_n && !full;
         do_rd = ld && !link.read_en_n && r.out_valid;
         // no refill under an offset read, or the byte would bury a word unseen
         pop = (r.mem_cnt != 17'h00000) && (!r.out_valid || do_rd) && !off_rd;
         if (do_wr) begin
            mem_we = 1'b1;
            s.wr_idx = r.wr_idx + 16'h0001;
         end
         // the output register refills itself, so the head word falls through
         if (pop) begin
            s.rdata = mem_q;
            s.rd_idx = r.rd_idx + 16'h0001;
            s.out_valid = 1'b1;
         end else if (do_rd) begin
            s.out_valid = 1'b0;
         end
         s.mem_cnt = r.mem_cnt + {16'h0000, do_wr} - {16'h0000, pop};

         if (off_wr && !r.method_serial) begin
            s.offs = off_put(r.offs, r.wptr, link.write_data_bus[7:0]);
            s.wptr = r.wptr + 2'h1;
         end
         // readback overwrites the word on the read bus; reading is the only view
         if (off_rd) begin
            s.rdata = {1'b0, off_byte(r.offs, r.rptr)};
            s.rptr = r.rptr + 2'h1;
         end
         // the position is kept across pauses of either select pin
         if (ser_shift && r.method_serial) begin
            s.offs[r.spos] = link.serial_in;
            s.spos = r.spos + 5'h01;
            s.ser_busy = !set_complete(r.spos);
         end
      end
      // thresholds freeze while a serial set is partly loaded, then follow
      // the new offsets one edge later; the flags take one edge more
      if (link.master_reset_n && !r.ser_busy) begin
         s.off_pipe = r.offs;
      end
   end

   always_ff @(posedge pclk) begin
      if (mem_we) begin
         mem[r.wr_idx] <= link.write_data_bus;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= DEV_RST;
      end else begin
         r <= s;
      end
   end

   flag_gen u_flags (
      .pclk(pclk),
      .presetn(presetn),
      .count(total),
      .empty_off(r.off_pipe[15:0]),
      .full_off(r.off_pipe[31:16]),
      .almost_empty_flag(link.almost_empty_flag),
      .half_full_flag(link.half_full_flag),
      .almost_full_flag(link.almost_full_flag)
   );

   assign link.read_data_bus = r.rdata;
   assign link.output_ready_flag = !r.out_valid;
   assign link.input_ready_flag = full;
   assign serial_method = r.method_serial;
   assign program_busy = r.ser_busy;
endmodule

// file: hw/fifo_flag_cfg.svh
`ifndef FIFO_FLAG_CFG_SVH
`define FIFO_FLAG_CFG_SVH

// memory words; the output register adds one more word of capacity
`define FIFO_DEPTH 17'h10000
`define FIFO_CAP 17'h10001
`define FIFO_HALF_LVL 17'h8002
`define OFF_DEF_PAR 16'h007F
`define OFF_DEF_SER 16'h03FF
`define SER_LAST_BIT 5'h1F

`define REG_CMD 12'h000
`define REG_TXDATA 12'h004
`define REG_RXDATA 12'h008
`define REG_STATUS 12'h00C
`define REG_IRQ_STAT 12'h010
`define REG_IRQ_MASK 12'h014

`define CMD_ARG_BIT 8
`define IRQ_DONE 0
`define IRQ_AVAIL 1
`define IRQ_FULL 2
`define IRQ_RST 3'h0

`endif

// file: hw/fifo_flag_pkg.sv
package fifo_flag_pkg;

   typedef enum logic [2:0] {
      OP_NOP,
      OP_MEM_WR,
      OP_MEM_RD,
      OP_OFF_WR,
      OP_OFF_RD,
      OP_SER_BIT,
      OP_MRESET
   } link_op_t;

   typedef enum logic [1:0] {
      H_IDLE,
      H_OP,
      H_CAPT
   } host_fsm_t;

   typedef struct packed {
      logic method_serial;
      logic out_valid;
      logic [8:0] rdata;
      logic [15:0] wr_idx;
      logic [15:0] rd_idx;
      logic [16:0] mem_cnt;
      logic [31:0] offs;
      logic [31:0] off_pipe;
      logic [1:0] wptr;
      logic [1:0] rptr;
      logic [4:0] spos;
      logic ser_busy;
   } dev_state_t;

   typedef struct packed {
      logic ae;
      logic hf;
      logic af;
   } flag_state_t;

   typedef struct packed {
      host_fsm_t state;
      link_op_t op;
      logic arg;
      logic [8:0] tx_data;
      logic [8:0] rx_data;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
      logic [31:0] prdata;
      logic or_prev;
      logic ir_prev;
      logic p_ld;
      logic p_we_n;
      logic p_re_n;
      logic p_sen_n;
      logic p_si;
      logic p_mr_n;
      logic [8:0] p_data;
   } host_state_t;

endpackage

// file: hw/fifo_host.sv
`timescale 1ns/100ps
`include "fifo_flag_cfg.svh"
module fifo_host
   import fifo_flag_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   fifo_link_if.host link
);
   localparam host_state_t HOST_RST = '{
      state: H_IDLE,
      op: OP_NOP,
      arg: 1'b0,
      tx_data: 9'h000,
      rx_data: 9'h000,
      irq_stat: `IRQ_RST,
      irq_mask: `IRQ_RST,
      prdata: 32'h00000000,
      or_prev: 1'b1,
      ir_prev: 1'b0,
      p_ld: 1'b1,
      p_we_n: 1'b1,
      p_re_n: 1'b1,
      p_sen_n: 1'b1,
      p_si: 1'b0,
      p_mr_n: 1'b1,
      p_data: 9'h000
   };

   host_state_t r;
   host_state_t s;
   logic cmd_wr;
   logic wr_acc;
   logic [2:0] ev;
   logic [2:0] w1c;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      return a == off;
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      return hit(a, `REG_CMD) || hit(a, `REG_TXDATA) || hit(a, `REG_RXDATA) ||
         hit(a, `REG_STATUS) || hit(a, `REG_IRQ_STAT) || hit(a, `REG_IRQ_MASK);
   endfunction

   // a command write stalls the bus until the previous one has finished
   assign cmd_wr = psel && penable && pwrite && hit(paddr, `REG_CMD);
   assign pready = !(cmd_wr && (r.state != H_IDLE));
   assign pslverr = psel && penable && !mapped(paddr);
   assign wr_acc = psel && penable && pwrite && pready && mapped(paddr);

   always_comb begin
      s = r;
      ev = 3'h0;
      w1c = 3'h0;
      s.or_prev = link.output_ready_flag;
      s.ir_prev = link.input_ready_flag;
      ev[`IRQ_AVAIL] = r.or_prev && !link.output_ready_flag;
      ev[`IRQ_FULL] = !r.ir_prev && link.input_ready_flag;
      if (psel && !penable) begin
         case (paddr)
            `REG_CMD: s.prdata = {23'h000000, r.arg, 5'h00, r.op};
            `REG_TXDATA: s.prdata = {23'h000000, r.tx_data};
            `REG_RXDATA: s.prdata = {23'h000000, r.rx_data};
            `REG_STATUS: s.prdata = {26'h0000000, (r.state != H_IDLE),
               link.input_ready_flag, link.almost_full_flag, link.half_full_flag,
               link.almost_empty_flag, link.output_ready_flag};
            `REG_IRQ_STAT: s.prdata = {29'h00000000, r.irq_stat};
            `REG_IRQ_MASK: s.prdata = {29'h00000000, r.irq_mask};
            default: s.prdata = 32'h00000000;
         endcase
      end
      if (wr_acc && hit(paddr, `REG_TXDATA)) begin
         s.tx_data = pwdata[8:0];
      end
      if (wr_acc && hit(paddr, `REG_IRQ_MASK)) begin
         s.irq_mask = pwdata[2:0];
      end
      if (wr_acc && hit(paddr, `REG_IRQ_STAT)) begin
         w1c = pwdata[2:0];
      end
      case (r.state)
         H_IDLE: begin
            if (wr_acc && hit(paddr, `REG_CMD)) begin
               s.op = link_op_t'(pwdata[2:0]);
               s.arg = pwdata[`CMD_ARG_BIT];
               s.state = H_OP;
               s.p_data = r.tx_data;
               case (link_op_t'(pwdata[2:0]))
                  OP_MEM_WR: s.p_we_n = 1'b0;
                  OP_MEM_RD: s.p_re_n = 1'b0;
                  OP_OFF_WR: begin
                     s.p_ld = 1'b0;
                     s.p_we_n = 1'b0;
                  end
                  OP_OFF_RD: begin
                     s.p_ld = 1'b0;
                     s.p_re_n = 1'b0;
                  end
                  OP_SER_BIT: begin
                     s.p_ld = 1'b0;
                     s.p_sen_n = 1'b0;
                     s.p_si = pwdata[`CMD_ARG_BIT];
                  end
                  OP_MRESET: begin
                     s.p_mr_n = 1'b0;
                     s.p_ld = pwdata[`CMD_ARG_BIT];
                  end
                  default: s.p_ld = 1'b1;
               endcase
            end
         end
         H_OP: begin
            // every op is one link cycle; idle pins pause serial loading
            s.p_ld = 1'b1;
            s.p_we_n = 1'b1;
            s.p_re_n = 1'b1;
            s.p_sen_n = 1'b1;
            s.p_mr_n = 1'b1;
            if (r.op == OP_MEM_RD) begin
               s.rx_data = link.read_data_bus;
            end
            s.state = H_CAPT;
         end
         H_CAPT: begin
            if (r.op == OP_OFF_RD) begin
               s.rx_data = link.read_data_bus;
            end
            ev[`IRQ_DONE] = 1'b1;
            s.state = H_IDLE;
         end
         default: s.state = H_IDLE;
      endcase
      s.irq_stat = (r.irq_stat & ~w1c) | ev;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= HOST_RST;
      end else begin
         r <= s;
      end
   end

   assign prdata = r.prdata;
   assign irq = |(r.irq_stat & r.irq_mask);
   assign link.master_reset_n = r.p_mr_n;
   assign link.offset_load_select = r.p_ld;
   assign link.write_en_n = r.p_we_n;
   assign link.read_en_n = r.p_re_n;
   assign link.serial_enable_n = r.p_sen_n;
   assign link.serial_in = r.p_si;
   assign link.write_data_bus = r.p_data;
endmodule

// file: hw/fifo_link_if.sv
`timescale 1ns/100ps
interface fifo_link_if;
   logic master_reset_n;
   logic offset_load_select;
   logic write_en_n;
   logic read_en_n;
   logic serial_enable_n;
   logic serial_in;
   logic [8:0] write_data_bus;
   logic [8:0] read_data_bus;
   logic output_ready_flag;
   logic input_ready_flag;
   logic almost_empty_flag;
   logic half_full_flag;
   logic almost_full_flag;

   modport device (
      input master_reset_n, offset_load_select, write_en_n, read_en_n,
      input serial_enable_n, serial_in, write_data_bus,
      output read_data_bus, output_ready_flag, input_ready_flag,
      output almost_empty_flag, half_full_flag, almost_full_flag
   );

   modport host (
      output master_reset_n, offset_load_select, write_en_n, read_en_n,
      output serial_enable_n, serial_in, write_data_bus,
      input read_data_bus, output_ready_flag, input_ready_flag,
      input almost_empty_flag, half_full_flag, almost_full_flag
   );
endinterface

// file: hw/flag_gen.sv
`timescale 1ns/100ps
`include "fifo_flag_cfg.svh"
module flag_gen
   import fifo_flag_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [16:0] count,
   input wire logic [15:0] empty_off,
   input wire logic [15:0] full_off,
   output logic almost_empty_flag,
   output logic half_full_flag,
   output logic almost_full_flag
);
   flag_state_t r;
   flag_state_t s;

   // flags are active low; 18-bit sums keep n+1 and count+m from wrapping
   always_comb begin
      s = r;
      s.ae = ({1'b0, count} > ({2'b00, empty_off} + 18'h00001));
      s.hf = (count < `FIFO_HALF_LVL);
      s.af = (({1'b0, count} + {2'b00, full_off}) < {1'b0, `FIFO_CAP});
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= 3'b011;
      end else begin
         r <= s;
      end
   end

   assign almost_empty_flag = r.ae;
   assign half_full_flag = r.hf;
   assign almost_full_flag = r.af;
endmodule

// file: verification/fifo_link_chk.sv
`timescale 1ns/100ps
module fifo_link_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic master_reset_n,
   input wire logic offset_load_select,
   input wire logic write_en_n,
   input wire logic read_en_n,
   input wire logic serial_enable_n,
   input wire logic [8:0] read_data_bus,
   input wire logic output_ready_flag,
   input wire logic input_ready_flag,
   input wire logic almost_empty_flag,
   input wire logic half_full_flag,
   input wire logic almost_full_flag
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence mem_wr_s;
      offset_load_select && !write_en_n && master_reset_n;
   endsequence
   sequence cleared_s;
      output_ready_flag && !input_ready_flag && !almost_empty_flag && half_full_flag;
   endsequence

   mrst_clear_a: assert property (!master_reset_n |-> ##2 cleared_s)
      else $error("flags not cleared after master reset");
   fall_thru_a: assert property (output_ready_flag ##0 mem_wr_s |-> ##[1:3] !output_ready_flag)
      else $error("first word did not fall through");
   empty_blk_a: assert property (output_ready_flag && offset_load_select && !read_en_n
      && write_en_n |=> output_ready_flag)
      else $error("read from empty fifo not blocked");
   offwr_quiet_a: assert property (!offset_load_select && !write_en_n
      |=> $stable(output_ready_flag) && $stable(read_data_bus))
      else $error("offset write disturbed the output side");
   offrd_byte_a: assert property (!offset_load_select && !read_en_n && write_en_n
      |=> read_data_bus[8] == 1'b0)
      else $error("offset readback not a byte");
   ser_hold_a: assert property (!offset_load_select && !serial_enable_n
      |=> $stable(almost_empty_flag) && $stable(almost_full_flag))
      else $error("partial flag moved during serial shift");
   we_pulse_a: assert property (!write_en_n |=> write_en_n [*2])
      else $error("write strobe too long or too close");
   re_pulse_a: assert property ($fell(read_en_n) |=> read_en_n ##1 read_en_n)
      else $error("read strobe too long or too close");
endmodule

// file: verification/testbench.sv
`timescale 1ns/100ps
`include "fifo_flag_cfg.svh"
module testbench
   import fifo_flag_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic serial_method;
   logic program_busy;
   int fail_count = 0;
   int num_checks = 0;
   int cycles = 0;

   fifo_link_if link ();
   fifo_dev u_fifo_dev (.pclk(pclk), .presetn(presetn), .link(link),
      .serial_method(serial_method), .program_busy(program_busy));
   fifo_host u_fifo_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .link(link));
   fifo_link_chk u_fifo_link_chk (.pclk(pclk), .presetn(presetn),
      .master_reset_n(link.master_reset_n), .offset_load_select(link.offset_load_select),
      .write_en_n(link.write_en_n), .read_en_n(link.read_en_n),
      .serial_enable_n(link.serial_enable_n), .read_data_bus(link.read_data_bus),
      .output_ready_flag(link.output_ready_flag), .input_ready_flag(link.input_ready_flag),
      .almost_empty_flag(link.almost_empty_flag), .half_full_flag(link.half_full_flag),
      .almost_full_flag(link.almost_full_flag));

   always #12.5 pclk = ~pclk;

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // the request stands until the edge that sees pready high; the answer is taken there
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      logic e;
      apb(1'b0, a, 32'h0, d, e);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic op(input logic [2:0] c, input logic a);
      logic [31:0] s;
      wr(`REG_CMD, {23'h0, a, 5'h0, c});
      s = 32'h20;
      for (int i = 0; i < 8 && s[5] !== 1'b0; i++) rd(`REG_STATUS, s);
   endtask

   task automatic stat(input logic [4:0] exp);
      logic [31:0] r;
      rd(`REG_STATUS, r);
      chk({27'h0, r[4:0]}, {27'h0, exp});
   endtask

   task automatic offs_chk(input logic [31:0] exp);
      logic [31:0] r;
      for (int i = 0; i < 4; i++) begin
         op(3'h4, 1'b0);
         rd(`REG_RXDATA, r);
         chk(r, {24'h0, exp[8*i +: 8]});
      end
   endtask

   task automatic t_reset;
      logic [31:0] r;
      logic e;
      stat(5'h0D);
      rd(`REG_IRQ_MASK, r);
      chk(r, 32'h0);
      apb(1'b0, 12'h020, 32'h0, r, e);
      chk({31'h0, e}, 32'h1);
      chk(r, 32'h0);
      $display("test reset done");
   endtask

   task automatic t_defaults;
      for (int s = 0; s < 2; s++) begin
         op(3'h6, s[0]);
         chk({31'h0, serial_method}, s);
         offs_chk(s[0] ? 32'h03FF03FF : 32'h007F007F);
      end
      $display("test defaults done");
   endtask

   task automatic t_parallel;
      logic [31:0] r;
      logic [31:0] v;
      v = 32'hFFFF0002;
      op(3'h6, 1'b0);
      for (int i = 0; i < 4; i++) begin
         wr(`REG_TXDATA, {24'h0, v[8*i +: 8]});
         op(3'h3, 1'b0);
      end
      op(3'h5, 1'b1);
      offs_chk(v);
      wr(`REG_IRQ_MASK, 32'h2);
      wr(`REG_IRQ_STAT, 32'h7);
      chk({31'h0, irq}, 32'h0);
      for (int k = 1; k <= 5; k++) begin
         wr(`REG_TXDATA, 32'h1A0 + k);
         op(3'h1, 1'b0);
         stat({1'b0, k < 2, 1'b1, k >= 4, 1'b0});
         if (k == 1) begin
            chk({31'h0, irq}, 32'h1);
            wr(`REG_IRQ_STAT, 32'h2);
            // the clear lands at the edge that ends the write; look one edge on
            @(posedge pclk);
            chk({31'h0, irq}, 32'h0);
         end
      end
      for (int k = 1; k <= 5; k++) begin
         op(3'h2, 1'b0);
         rd(`REG_RXDATA, r);
         chk(r, 32'h1A0 + k);
      end
      stat(5'h0D);
      op(3'h2, 1'b0);
      stat(5'h0D);
      $display("test parallel done");
   endtask

   // word written mid-sequence proves memory access and resume in place
   task automatic t_serial;
      logic [31:0] v;
      v = 32'hFFFF0003;
      op(3'h6, 1'b1);
      chk({31'h0, serial_method}, 32'h1);
      for (int i = 0; i < 32; i++) begin
         if (i == 10) begin
            wr(`REG_TXDATA, 32'h1A5);
            op(3'h1, 1'b0);
            op(3'h3, 1'b0);
            chk({31'h0, program_busy}, 32'h1);
         end
         op(3'h5, v[i]);
      end
      chk({31'h0, program_busy}, 32'h0);
      offs_chk(v);
      stat(5'h0C);
      wr(`REG_TXDATA, 32'h15A);
      op(3'h1, 1'b0);
      stat(5'h04);
      $display("test serial done");
   endtask

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_defaults();
      t_parallel();
      t_serial();
      tally_and_finish();
   end
endmodule
